/* File: lane_status_defs.svh */
// Address map, field positions, reset values and widths of the lane status block.
`ifndef LANE_STATUS_DEFS_SVH
`define LANE_STATUS_DEFS_SVH

`define LANE_CNT 4
`define DATA_W 16
`define ADDR_W 8

`define ADDR_LANE_STATUS 8'h16
`define ADDR_LANE_CTRL 8'h30
`define ADDR_IRQ_STATUS 8'h31
`define ADDR_IRQ_MASK 8'h32

`define COLL_LSB 12
`define DEC_LSB 8
`define PASS_LSB 4
`define LOSS_LSB 0
`define LOSS_EN_LSB 0
`define PAT_EN_LSB 4

`define FLAG_RST 4'h0
`define PASS_RST 4'hF
`define PASS_ALL 4'hF
`define LOSS_EN_RST 4'hF
`define PAT_EN_RST 4'h0
`define WORD_ZERO 16'h0000
`define IRQ_MASK_RST 16'h0000

`endif

/* File: lane_status_pkg.sv */
// Types shared by the lane status block.
`include "lane_status_defs.svh"

package lane_status_pkg;
   typedef logic [`LANE_CNT-1:0] lane_vec_t;
   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`ADDR_W-1:0] addr_t;
endpackage : lane_status_pkg

/* File: lane_flag_if.sv */
// Bundle between the register front end and the per-lane flag capture.
`timescale 1ns/1ps

interface lane_flag_if;
   import lane_status_pkg::*;
   lane_vec_t tx_collision;
   lane_vec_t decode_err;
   lane_vec_t pattern_err;
   lane_vec_t loss_detect;
   lane_vec_t loss_en;
   lane_vec_t pattern_en;
   logic rd_clear;
   lane_vec_t coll_flag;
   lane_vec_t dec_flag;
   lane_vec_t pattern_check_ok;
   lane_vec_t signal_loss_flag;

   modport owner (
      output tx_collision, decode_err, pattern_err, loss_detect, loss_en, pattern_en, rd_clear,
      input coll_flag, dec_flag, pattern_check_ok, signal_loss_flag
   );
   modport capture (
      input tx_collision, decode_err, pattern_err, loss_detect, loss_en, pattern_en, rd_clear,
      output coll_flag, dec_flag, pattern_check_ok, signal_loss_flag
   );
endinterface : lane_flag_if

/* File: lane_flag_capture.sv */
// Per-lane sticky event flags and pattern pass flags.
`timescale 1ns/1ps
`include "lane_status_defs.svh"

module lane_flag_capture
   import lane_status_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   lane_flag_if.capture lf
);
   lane_vec_t coll;
   lane_vec_t dec;
   lane_vec_t pass;
   lane_vec_t loss;
   lane_vec_t next_coll;
   lane_vec_t next_dec;
   lane_vec_t next_pass;
   lane_vec_t next_loss;

   // The set term is ORed after the clear so an event in the clearing cycle survives; for the pass flag the test failure is ANDed after the restore.
   for (genvar i = 0; i < `LANE_CNT; i++)
   begin : g_lane
      wire pat_fail = lf.pattern_err[i] & lf.pattern_en[i];
      assign next_coll[i] = lf.tx_collision[i] | (coll[i] & ~lf.rd_clear);
      assign next_dec[i] = lf.decode_err[i] | (dec[i] & ~lf.rd_clear);
      assign next_loss[i] = (lf.loss_detect[i] & lf.loss_en[i]) | (loss[i] & ~lf.rd_clear);
      assign next_pass[i] = ~pat_fail & (pass[i] | lf.rd_clear);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         coll <= `FLAG_RST;
         dec <= `FLAG_RST;
         pass <= `PASS_RST;
         loss <= `FLAG_RST;
      end
      else
      begin
         coll <= next_coll;
         dec <= next_dec;
         pass <= next_pass;
         loss <= next_loss;
      end
   end

   assign lf.coll_flag = coll;
   assign lf.dec_flag = dec;
   assign lf.pattern_check_ok = pass;
   assign lf.signal_loss_flag = loss;
endmodule : lane_flag_capture

/* File: lane_status_flags.sv */
// Lane status register bank with read-to-clear flags, lane control and interrupt.
`timescale 1ns/1ps
`include "lane_status_defs.svh"

module lane_status_flags
   import lane_status_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire addr_t addr,
   input wire word_t wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output word_t rdata,
   input wire lane_vec_t tx_collision,
   input wire lane_vec_t decode_err,
   input wire lane_vec_t pattern_err,
   input wire lane_vec_t loss_detect,
   output lane_vec_t loss_detect_en,
   output lane_vec_t pattern_test_en,
   output logic irq
);
   lane_flag_if lf ();

   lane_vec_t loss_en;
   lane_vec_t pat_en;
   word_t irq_status;
   word_t irq_mask;
   word_t next_irq_status;

   // Address decode.
   wire hit_status = (addr == `ADDR_LANE_STATUS);
   wire hit_ctrl = (addr == `ADDR_LANE_CTRL);
   wire hit_irq_status = (addr == `ADDR_IRQ_STATUS);
   wire hit_irq_mask = (addr == `ADDR_IRQ_MASK);
   wire rd_status = rd_stb & hit_status;
   wire wr_ctrl = wr_stb & hit_ctrl;
   wire wr_irq_status = wr_stb & hit_irq_status;
   wire wr_irq_mask = wr_stb & hit_irq_mask;

   // Only a read of the status word clears; other reads have no side effect.
   assign lf.rd_clear = rd_status;
   assign lf.tx_collision = tx_collision;
   assign lf.decode_err = decode_err;
   assign lf.pattern_err = pattern_err;
   assign lf.loss_detect = loss_detect;
   assign lf.loss_en = loss_en;
   assign lf.pattern_en = pat_en;

   lane_flag_capture u_capture (
      .clk(clk),
      .sys_rst(sys_rst),
      .lf(lf.capture)
   );

   // Status word as software sees it.
   word_t status_word;
   assign status_word[`COLL_LSB +: `LANE_CNT] = lf.coll_flag;
   assign status_word[`DEC_LSB +: `LANE_CNT] = lf.dec_flag;
   assign status_word[`PASS_LSB +: `LANE_CNT] = lf.pattern_check_ok;
   assign status_word[`LOSS_LSB +: `LANE_CNT] = lf.signal_loss_flag;

   word_t ctrl_word;
   assign ctrl_word = {{(`DATA_W - 2 * `LANE_CNT){1'b0}}, pat_en, loss_en};

   // Interrupt events share the status layout; gated events never raise one.
   word_t irq_event;
   assign irq_event[`COLL_LSB +: `LANE_CNT] = tx_collision;
   assign irq_event[`DEC_LSB +: `LANE_CNT] = decode_err;
   assign irq_event[`PASS_LSB +: `LANE_CNT] = pattern_err & pat_en;
   assign irq_event[`LOSS_LSB +: `LANE_CNT] = loss_detect & loss_en;

   wire word_t irq_clear = wr_irq_status ? wdata : `WORD_ZERO;
   assign next_irq_status = irq_event | (irq_status & ~irq_clear);

   wire word_t read_mux = hit_status ? status_word :
                          hit_ctrl ? ctrl_word :
                          hit_irq_status ? irq_status :
                          hit_irq_mask ? irq_mask : `WORD_ZERO;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         loss_en <= `LOSS_EN_RST;
         pat_en <= `PAT_EN_RST;
      end
      else if (wr_ctrl)
      begin
         loss_en <= wdata[`LOSS_EN_LSB +: `LANE_CNT];
         pat_en <= wdata[`PAT_EN_LSB +: `LANE_CNT];
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         irq_status <= `WORD_ZERO;
         irq_mask <= `IRQ_MASK_RST;
      end
      else
      begin
         irq_status <= next_irq_status;
         if (wr_irq_mask)
         begin
            irq_mask <= wdata;
         end
      end
   end

   // Read data is the word before the clearing edge, so the reported events are those cleared.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata <= `WORD_ZERO;
      end
      else
      begin
         rdata <= rd_stb ? read_mux : `WORD_ZERO;
      end
   end

   assign irq = |(irq_status & irq_mask);
   assign loss_detect_en = loss_en;
   assign pattern_test_en = pat_en;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_status_read;
      rd_stb && hit_status;
   endsequence

   sequence s_quiet_read;
      s_status_read ##0 (tx_collision == `FLAG_RST && decode_err == `FLAG_RST && loss_detect == `FLAG_RST);
   endsequence

   sequence s_pass_dropped;
      lf.pattern_check_ok != `PASS_ALL;
   endsequence

   AST_COLL_SET: assert property (
      (tx_collision != `FLAG_RST) |=> ((lf.coll_flag & $past(tx_collision)) == $past(tx_collision)))
      else $error("collision flag not set by event");

   AST_DEC_SET: assert property (
      (decode_err != `FLAG_RST) |=> ((lf.dec_flag & $past(decode_err)) == $past(decode_err)))
      else $error("decode flag not set by event");

   AST_PASS_DROP: assert property (
      ((pattern_err & pat_en) != `FLAG_RST) |=> ((lf.pattern_check_ok & $past(pattern_err & pat_en)) == `FLAG_RST))
      else $error("pass flag did not drop on test error");

   AST_PASS_RESTORE: assert property (
      (s_pass_dropped ##0 s_status_read) |=> (lf.pattern_check_ok == ~$past(pattern_err & pat_en)))
      else $error("pass flag not restored by read");

   AST_LOSS_SET: assert property (
      ((loss_detect & loss_en) != `FLAG_RST) |=> ((lf.signal_loss_flag & $past(loss_detect & loss_en)) ==
                                                   $past(loss_detect & loss_en)))
      else $error("loss flag not set by enabled event");

   AST_READ_CLEARS: assert property (
      s_quiet_read |=> (lf.coll_flag == `FLAG_RST && lf.dec_flag == `FLAG_RST && lf.signal_loss_flag == `FLAG_RST))
      else $error("read did not clear event flags");

   AST_READ_DATA: assert property (
      s_status_read |=> (rdata == $past(status_word)))
      else $error("read data is not the pre-clear status");

   AST_LOSS_GATED: assert property (
      ((lf.signal_loss_flag & ~$past(lf.signal_loss_flag) & ~$past(loss_detect & loss_en)) == `FLAG_RST))
      else $error("loss flag rose without an enabled event");

   AST_PASS_GATED: assert property (
      ((~lf.pattern_check_ok & $past(lf.pattern_check_ok) & ~$past(pattern_err & pat_en)) == `FLAG_RST))
      else $error("pass flag fell without an enabled test error");

   AST_READ_KEEPS_EVENT: assert property (
      (s_status_read ##0 ((tx_collision | decode_err | (loss_detect & loss_en)) != `FLAG_RST))
      |=> (((lf.coll_flag & $past(tx_collision)) | (lf.dec_flag & $past(decode_err)) |
            (lf.signal_loss_flag & $past(loss_detect & loss_en))) ==
           ($past(tx_collision) | $past(decode_err) | $past(loss_detect & loss_en))))
      else $error("event lost in clearing read cycle");

   AST_IRQ_STICKY: assert property (
      (irq_event != `WORD_ZERO) |=> ((irq_status & $past(irq_event)) == $past(irq_event)))
      else $error("interrupt status missed an event");

   AST_RDATA_IDLE: assert property (
      !rd_stb |=> (rdata == `WORD_ZERO))
      else $error("read data not zero outside a read answer");

   AST_CTRL_WRITE: assert property (
      wr_ctrl |=> (loss_en == $past(wdata[`LOSS_EN_LSB +: `LANE_CNT]) &&
                   pat_en == $past(wdata[`PAT_EN_LSB +: `LANE_CNT])))
      else $error("lane control write did not land");

   AST_PASS_RISE_ON_READ: assert property (
      ((lf.pattern_check_ok & ~$past(lf.pattern_check_ok)) != `FLAG_RST) |-> $past(rd_status))
      else $error("pass flag rose without a status read");

   AST_EVENT_FLAG_HOLD: assert property (
      !rd_status |=> ((lf.coll_flag & $past(lf.coll_flag)) == $past(lf.coll_flag) &&
                      (lf.dec_flag & $past(lf.dec_flag)) == $past(lf.dec_flag)))
      else $error("collision or decode flag cleared without a read");

   AST_LOSS_HOLD: assert property (
      !rd_status |=> ((lf.signal_loss_flag & $past(lf.signal_loss_flag)) == $past(lf.signal_loss_flag)))
      else $error("loss flag cleared without a read");

   AST_IRQ_W1C: assert property (
      (wr_irq_status && irq_event == `WORD_ZERO) |=> ((irq_status & $past(wdata)) == `WORD_ZERO))
      else $error("interrupt status bit not cleared by writing one");
endmodule : lane_status_flags

/* File: lane_status_flags_tb.sv */
// Self-checking bench for the lane status register bank.
`timescale 1ns/1ps
`include "lane_status_defs.svh"
`define CHK(nm, e, g) \
   begin \
      checks++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("BAD %s exp %h got %h", nm, e, g); \
      end \
   end

module lane_status_flags_tb;
   import lane_status_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   addr_t addr = 8'h00;
   word_t wdata = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   word_t rdata;
   lane_vec_t tx_collision = 4'h0;
   lane_vec_t decode_err = 4'h0;
   lane_vec_t pattern_err = 4'h0;
   lane_vec_t loss_detect = 4'h0;
   lane_vec_t loss_detect_en;
   lane_vec_t pattern_test_en;
   logic irq;
   int err_count = 0;
   int checks = 0;

   lane_status_flags i_lane_status_flags (
      .clk(clk),
      .sys_rst(sys_rst),
      .addr(addr),
      .wdata(wdata),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .rdata(rdata),
      .tx_collision(tx_collision),
      .decode_err(decode_err),
      .pattern_err(pattern_err),
      .loss_detect(loss_detect),
      .loss_detect_en(loss_detect_en),
      .pattern_test_en(pattern_test_en),
      .irq(irq)
   );

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task automatic wr(input addr_t a, input word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      #1;
   endtask : wr

   // Read data is registered, so it is judged just after the edge that ends the strobe.
   task automatic rd(input addr_t a, input word_t e, input string nm);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      `CHK(nm, e, rdata)
   endtask : rd

   task automatic ev(input lane_vec_t c, input lane_vec_t d, input lane_vec_t p, input lane_vec_t l);
      @(posedge clk);
      tx_collision <= c;
      decode_err <= d;
      pattern_err <= p;
      loss_detect <= l;
      @(posedge clk);
      tx_collision <= 4'h0;
      decode_err <= 4'h0;
      pattern_err <= 4'h0;
      loss_detect <= 4'h0;
      #1;
   endtask : ev

   task automatic t_reset();
      rd(`ADDR_LANE_STATUS, 16'h00F0, "status_rst");
      rd(`ADDR_LANE_CTRL, 16'h000F, "ctrl_rst");
      `CHK("loss_en_rst", 4'hF, loss_detect_en)
      `CHK("pat_en_rst", 4'h0, pattern_test_en)
      `CHK("irq_rst", 1'b0, irq)
      rd(8'h40, 16'h0000, "unmapped");
   endtask : t_reset

   task automatic t_events();
      ev(4'h1, 4'h2, 4'h0, 4'h8);
      rd(`ADDR_LANE_STATUS, 16'h12F8, "status_events");
      rd(`ADDR_LANE_STATUS, 16'h00F0, "status_cleared");
      wr(`ADDR_LANE_STATUS, 16'hFFFF);
      rd(`ADDR_LANE_STATUS, 16'h00F0, "status_ro");
   endtask : t_events

   task automatic t_enables();
      wr(`ADDR_LANE_CTRL, 16'h00F0);
      `CHK("loss_en_off", 4'h0, loss_detect_en)
      `CHK("pat_en_on", 4'hF, pattern_test_en)
      ev(4'h0, 4'h0, 4'h5, 4'hF);
      rd(`ADDR_LANE_STATUS, 16'h00A0, "pass_drop");
      rd(`ADDR_LANE_STATUS, 16'h00F0, "pass_restore");
      wr(`ADDR_LANE_CTRL, 16'h000F);
      ev(4'h0, 4'h0, 4'hF, 4'h0);
      rd(`ADDR_LANE_STATUS, 16'h00F0, "pass_disabled");
   endtask : t_enables

   // An event landing on the clearing read must survive into the next read.
   task automatic t_same_cycle();
      ev(4'h2, 4'h0, 4'h0, 4'h0);
      @(posedge clk);
      decode_err <= 4'h4;
      addr <= `ADDR_LANE_STATUS;
      rd_stb <= 1'b1;
      @(posedge clk);
      decode_err <= 4'h0;
      rd_stb <= 1'b0;
      #1;
      `CHK("read_with_event", 16'h20F0, rdata)
      rd(`ADDR_LANE_STATUS, 16'h04F0, "event_kept");
   endtask : t_same_cycle

   task automatic t_irq();
      wr(`ADDR_IRQ_STATUS, 16'hFFFF);
      rd(`ADDR_IRQ_STATUS, 16'h0000, "irq_st_clr");
      wr(`ADDR_IRQ_MASK, 16'h0200);
      `CHK("irq_idle", 1'b0, irq)
      ev(4'h1, 4'h2, 4'h0, 4'h0);
      `CHK("irq_dec", 1'b1, irq)
      rd(`ADDR_IRQ_STATUS, 16'h1200, "irq_st");
      wr(`ADDR_IRQ_MASK, 16'h0000);
      `CHK("irq_masked", 1'b0, irq)
      wr(`ADDR_IRQ_STATUS, 16'h0200);
      rd(`ADDR_IRQ_STATUS, 16'h1000, "irq_w1c");
      wr(`ADDR_IRQ_MASK, 16'h1000);
      `CHK("irq_coll", 1'b1, irq)
      wr(`ADDR_IRQ_STATUS, 16'h1000);
      `CHK("irq_off", 1'b0, irq)
      ev(4'h0, 4'h0, 4'h3, 4'h4);
      rd(`ADDR_IRQ_STATUS, 16'h0004, "irq_st_gated");
   endtask : t_irq

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   // The whole sequence needs well under a thousand cycles.
   initial
   begin
      #(25 * 4000);
      err_count++;
      conclude();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_events();
      t_enables();
      t_same_cycle();
      t_irq();
      conclude();
   end
endmodule : lane_status_flags_tb
